/* File: rtl/threshold_alert_monitor.sv */
// threshold alert monitor with axi4-lite register access
// Notes on behaviour
// - channel a result above high limit sets flag bit 1.
// - channel a result below low limit sets flag bit 0.
// - flags stay set until the flag register is read or a soft or hard reset code is written.
// - internal low limit is the 12-bit field followed by four zeros.
// - low alert when result below internal low limit.
// - internal high limit is the 12-bit field followed by four ones.
// - high alert when result above internal high limit.
// - low limit register at index 4, resets to zero.
// - high limit register at index 5, resets to 0x0fff.
// - register address returned in bits 15:12 of every mapped read word; unmapped reads return zero.
// - channel b flags at bits 5 and 4, same limits.
// - soft reset code 0x3c clears flags, keeps limits.
`timescale 1ns/1ns
`include "alert_defs.svh"
module threshold_alert_monitor
  import alert_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // conversion results
  input  wire logic        i_res_valid,
  input  wire sample_t     i_res_a,
  input  wire sample_t     i_res_b,
  // axi4-lite write address and data
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // axi4-lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // axi4-lite read
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // interrupt and alert
  output logic             o_irq,
  output logic             o_alert
);

  logic [11:0] low_r;
  logic [11:0] high_r;
  logic [5:0]  flags_r;
  logic [5:0]  flags_nxt;
  logic [5:0]  irq_stat_r;
  logic [5:0]  irq_stat_nxt;
  logic [5:0]  irq_mask_r;
  logic        cmp_vld_r;
  sample_t     cmp_a_r;
  sample_t     cmp_b_r;
  logic        aw_held_r;
  logic [31:0] awaddr_r;
  logic        w_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // internal limits
  wire sample_t low_lim  = {low_r, `LOW_FILL};
  wire sample_t high_lim = {high_r, `HIGH_FILL};

  // per-channel event detection on the registered result
  wire sample_t res_ch[2];
  assign res_ch[0] = cmp_a_r;
  assign res_ch[1] = cmp_b_r;
  wire [5:0] hit;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      assign hit[4*g]   = cmp_vld_r && (res_ch[g] < low_lim);
      assign hit[4*g+1] = cmp_vld_r && (res_ch[g] > high_lim);
    end
  endgenerate
  // bits 3:2 are spare in the flag layout
  assign hit[3:2] = 2'b00;
  wire [5:0] hit_used = hit & 6'h33;

  // write channel decode
  wire        aw_have  = aw_held_r | (i_awvalid & o_awready);
  wire        w_have   = w_held_r | (i_wvalid & o_wready);
  wire [31:0] wr_addr  = aw_held_r ? awaddr_r : i_awaddr;
  wire [31:0] wr_data  = w_held_r ? wdata_r : i_wdata;
  wire [3:0]  wr_strb  = w_held_r ? wstrb_r : i_wstrb;
  wire        wr_fire  = aw_have && w_have && !o_bvalid;
  wire [3:0]  wr_idx   = wr_addr[5:2];
  wire        wr_inmap = (wr_addr[31:6] == 26'h0) && (wr_idx == `REG_IDX_SETUP2 || wr_idx == `REG_IDX_FLAGS ||
                         wr_idx == `REG_IDX_LOW || wr_idx == `REG_IDX_HIGH ||
                         wr_idx == `REG_IDX_IRQ_STAT || wr_idx == `REG_IDX_IRQ_MASK);
  wire        wr_lo    = wr_fire && wr_strb[0];
  wire        wr_hi    = wr_fire && wr_strb[1];
  wire        wr_both  = wr_lo && wr_hi;
  wire        soft_rst = wr_lo && wr_inmap && wr_idx == `REG_IDX_SETUP2 &&
                         wr_data[7:0] == `SOFT_RESET_CODE;
  wire        hard_rst = wr_lo && wr_inmap && wr_idx == `REG_IDX_SETUP2 &&
                         wr_data[7:0] == `HARD_RESET_CODE;

  // read channel decode
  wire        rd_fire  = i_arvalid && o_arready;
  wire [3:0]  rd_idx   = i_araddr[5:2];
  wire        rd_flags = rd_fire && i_araddr[31:6] == 26'h0 && rd_idx == `REG_IDX_FLAGS;
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = (i_araddr[31:6] == 26'h0);
    rd_word = 32'h0;
    unique case (rd_idx)
      `REG_IDX_SETUP2:   rd_word = {16'h0, `REG_IDX_SETUP2, 12'h0};
      `REG_IDX_FLAGS:    rd_word = {16'h0, `REG_IDX_FLAGS, 6'h0, flags_r};
      `REG_IDX_LOW:      rd_word = {16'h0, `REG_IDX_LOW, low_r};
      `REG_IDX_HIGH:     rd_word = {16'h0, `REG_IDX_HIGH, high_r};
      `REG_IDX_IRQ_STAT: rd_word = {16'h0, `REG_IDX_IRQ_STAT, 6'h0, irq_stat_r};
      `REG_IDX_IRQ_MASK: rd_word = {16'h0, `REG_IDX_IRQ_MASK, 6'h0, irq_mask_r};
      default:           rd_ok   = 1'b0;
    endcase
  end

  // sticky flags: a new event wins over the clear-on-read
  always_comb begin
    flags_nxt = flags_r;
    if (rd_flags || soft_rst || hard_rst) begin
      flags_nxt = 6'h0;
    end
    flags_nxt = flags_nxt | hit_used;
  end

  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_lo && wr_inmap && wr_idx == `REG_IDX_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~wr_data[5:0];
    end
    irq_stat_nxt = irq_stat_nxt | hit_used;
  end

  // result capture, one cycle before comparison
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_vld_r <= 1'b0;
      cmp_a_r   <= 16'h0;
      cmp_b_r   <= 16'h0;
    end else begin
      cmp_vld_r <= i_res_valid;
      cmp_a_r   <= i_res_a;
      cmp_b_r   <= i_res_b;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_r    <= 6'h0;
      irq_stat_r <= 6'h0;
    end else begin
      flags_r    <= flags_nxt;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // limit registers; hard reset restores defaults, soft reset leaves them
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_r  <= `LOW_RESET;
      high_r <= `HIGH_RESET;
    end else if (hard_rst) begin
      low_r  <= `LOW_RESET;
      high_r <= `HIGH_RESET;
    end else if (wr_both && wr_inmap && wr_idx == `REG_IDX_LOW) begin
      low_r  <= wr_data[`LIMIT_MSB:0];
    end else if (wr_both && wr_inmap && wr_idx == `REG_IDX_HIGH) begin
      high_r <= wr_data[`LIMIT_MSB:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_mask_r <= 6'h0;
    end else if (wr_lo && wr_inmap && wr_idx == `REG_IDX_IRQ_MASK) begin
      irq_mask_r <= wr_data[5:0] & 6'h33;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq   <= 1'b0;
      o_alert <= 1'b0;
    end else begin
      o_irq   <= |(irq_stat_nxt & irq_mask_r);
      o_alert <= |flags_nxt;
    end
  end

  // write address and data holding; each may arrive first
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 32'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= i_awaddr;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= i_wdata;
      wstrb_r  <= i_wstrb;
    end
  end

  // ready is registered; each high only while its own channel holds nothing and no write response is pending
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RESP_OKAY;
    end else begin
      o_awready <= !wr_fire && !o_bvalid && !(aw_held_r || (i_awvalid && o_awready)) ? 1'b1 : 1'b0;
      o_wready  <= !wr_fire && !o_bvalid && !(w_held_r || (i_wvalid && o_wready)) ? 1'b1 : 1'b0;
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_inmap ? `RESP_OKAY : `RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= `RESP_OKAY;
    end else begin
      o_arready <= !rd_fire && !o_rvalid && !o_arready;
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_ok ? rd_word : 32'h0;
        o_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // checks: flag setting
  low_alert_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cmp_vld_r && cmp_a_r < {low_r, 4'h0}) |=> flags_r[0])
    else $error("channel a under event lost");
  a_over_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cmp_vld_r && cmp_a_r > {high_r, 4'hf}) |=> flags_r[1])
    else $error("channel a over event lost");
  b_under_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cmp_vld_r && cmp_b_r < {low_r, 4'h0}) |=> flags_r[4])
    else $error("channel b under event lost");
  high_alert_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cmp_vld_r && cmp_b_r > {high_r, 4'hf}) |=> flags_r[5])
    else $error("channel b over event lost");
  over_a_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_res_valid && i_res_a > high_lim && !hard_rst ##1 !hard_rst |=> flags_r[1])
    else $error("channel a over not flagged two cycles after result");
  capture_delay_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_res_valid |=> cmp_vld_r && cmp_a_r == $past(i_res_a) && cmp_b_r == $past(i_res_b))
    else $error("result not captured one cycle after strobe");

  // checks: clearing, limits and fill bits
  sticky_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    flags_r[1] && !rd_flags && !soft_rst && !hard_rst |=> flags_r[1])
    else $error("sticky flag dropped without read");
  read_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rd_flags && !cmp_vld_r |=> flags_r == 6'h0)
    else $error("flags not cleared by read");
  soft_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    soft_rst && !cmp_vld_r |=> flags_r == 6'h0 && $stable(low_r) && $stable(high_r))
    else $error("soft reset misbehaved");
  hard_defaults_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    hard_rst && !cmp_vld_r |=> flags_r == 6'h0 && low_r == 12'h000 && high_r == 12'hfff)
    else $error("hard reset left limits or flags");
  no_false_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmp_vld_r && cmp_a_r >= low_lim && !rd_flags && !soft_rst && !hard_rst && !flags_r[0] |=> !flags_r[0])
    else $error("under flag set without cause");
  no_false_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmp_vld_r && cmp_a_r <= high_lim && !rd_flags && !soft_rst && !hard_rst && !flags_r[1] |=> !flags_r[1])
    else $error("over flag set without cause");
  b_under_cause_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmp_vld_r && cmp_b_r >= low_lim && !rd_flags && !soft_rst && !hard_rst && !flags_r[4] |=> !flags_r[4])
    else $error("channel b under flag set without cause");
  b_over_cause_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmp_vld_r && cmp_b_r <= high_lim && !rd_flags && !soft_rst && !hard_rst && !flags_r[5] |=> !flags_r[5])
    else $error("channel b over flag set without cause");
  low_fill_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmp_vld_r && cmp_a_r[15:4] == low_r |-> !hit[0])
    else $error("result on the low field counted as under");
  high_fill_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmp_vld_r && cmp_a_r[15:4] == high_r |-> !hit[1])
    else $error("result on the high field counted as over");

  // checks: register access and pins
  read_addr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rd_fire && rd_idx == `REG_IDX_HIGH && i_araddr[31:6] == 26'h0 |=> o_rvalid && o_rdata[15:12] == 4'h5)
    else $error("read word lacks register address");
  read_flags_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rd_flags |=> o_rdata[15:12] == 4'h3 && o_rdata[5:0] == $past(flags_r))
    else $error("flag read returned wrong word");
  read_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rd_fire && rd_ok && rd_idx == `REG_IDX_LOW |=> o_rdata == {16'h0, 4'h4, $past(low_r)})
    else $error("low limit read returned wrong word");
  limit_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_both && wr_inmap && wr_idx == `REG_IDX_LOW |=> low_r == $past(wr_data[11:0]))
    else $error("low limit write not stored");
  unmapped_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rd_fire && !rd_ok |=> o_rvalid && o_rdata == 32'h0 && o_rresp == `RESP_SLVERR)
    else $error("unmapped read not refused");
  unmapped_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_fire && !wr_inmap |=> o_bvalid && o_bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
  alert_pin_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_alert == |flags_r)
    else $error("alert pin disagrees with flags");
  reset_vals_a: assert property (@(posedge i_clk)
    !i_nrst |=> (!i_nrst |-> low_r == 12'h0 && high_r == 12'hfff))
    else $error("limit reset values wrong");

endmodule : threshold_alert_monitor

/* File: rtl/alert_defs.svh */
// offsets, field positions and reset values for the threshold alert monitor
`ifndef ALERT_DEFS_SVH
`define ALERT_DEFS_SVH
`define REG_IDX_SETUP2      4'h2
`define REG_IDX_FLAGS       4'h3
`define REG_IDX_LOW         4'h4
`define REG_IDX_HIGH        4'h5
`define REG_IDX_IRQ_STAT    4'h8
`define REG_IDX_IRQ_MASK    4'h9
`define ADDR_MSB            15
`define ADDR_LSB            12
`define LIMIT_MSB           11
`define LOW_RESET           12'h000
`define HIGH_RESET          12'hfff
`define LOW_FILL            4'h0
`define HIGH_FILL           4'hf
`define SOFT_RESET_CODE     8'h3c
`define HARD_RESET_CODE     8'hff
`define BIT_A_UNDER         0
`define BIT_A_OVER          1
`define BIT_B_UNDER         4
`define BIT_B_OVER          5
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

/* File: rtl/alert_pkg.sv */
// types shared by the threshold alert monitor
package alert_pkg;
  typedef logic [15:0] sample_t;
  typedef logic [3:0]  flag4_t;
endpackage : alert_pkg

/* File: bench/host_model.sv */
// host controller model: axi4-lite master tasks
`timescale 1ns/1ns
module host_model (
  // clock
  input  wire logic        i_clk,
  // write channels
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_awaddr,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  input  wire logic [1:0]  i_bresp,
  // read channels
  output logic             o_arvalid,
  input  wire logic        i_arready,
  output logic [31:0]      o_araddr,
  input  wire logic        i_rvalid,
  output logic             o_rready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
    o_awaddr = 32'h0;
    o_wdata  = 32'h0;
    o_araddr = 32'h0;
    o_wstrb  = 4'h0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] idx, input logic [11:0] d, output logic [1:0] rsp);
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_awaddr  <= {26'h0, idx, 2'b00};
    o_wvalid  <= 1'b1;
    o_wdata   <= {16'h0, idx, d};
    o_wstrb   <= 4'hf;
    o_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_awready) o_awvalid <= 1'b0;
      if (i_wready) o_wvalid <= 1'b0;
    end while (!i_bvalid);
    rsp = i_bresp;
    o_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr  <= {26'h0, idx, 2'b00};
    o_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_arready) o_arvalid <= 1'b0;
    end while (!i_rvalid);
    d = i_rdata;
    rsp = i_rresp;
    o_rready <= 1'b0;
  endtask : rd
endmodule : host_model

/* File: bench/threshold_alert_monitor_tb.sv */
// self-checking bench for the threshold alert monitor
`timescale 1ns/1ns
`include "alert_defs.svh"
module threshold_alert_monitor_tb;
  logic               clk, nrst, rv, awv, awr, wv, wrd, bv, br, arv, arr, rvl, rr, irq, alert;
  logic [31:0]        awa, wd, ara, rdw, d;
  logic [3:0]         ws;
  logic [1:0]         bresp, rresp, rsp;
  logic [11:0]        lo, hi;
  logic [5:0]         ef;
  alert_pkg::sample_t ra, rb;
  int                 seed, n_mismatch, total_checks;
  threshold_alert_monitor dut_u (.i_clk(clk), .i_nrst(nrst), .i_res_valid(rv), .i_res_a(ra), .i_res_b(rb),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
    .i_wstrb(ws), .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rvl), .i_rready(rr), .o_rdata(rdw), .o_rresp(rresp), .o_irq(irq),
    .o_alert(alert));
  host_model hm (.i_clk(clk), .o_awvalid(awv), .i_awready(awr), .o_awaddr(awa), .o_wvalid(wv),
    .i_wready(wrd), .o_wdata(wd), .o_wstrb(ws), .i_bvalid(bv), .o_bready(br), .i_bresp(bresp),
    .o_arvalid(arv), .i_arready(arr), .o_araddr(ara), .i_rvalid(rvl), .o_rready(rr), .i_rdata(rdw),
    .i_rresp(rresp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // strict compares: a result equal to a limit raises nothing
  function automatic logic [1:0] lim(input logic [15:0] r);
    lim = {r > {hi, 4'hf}, r < {lo, 4'h0}};
  endfunction : lim
  function automatic logic [15:0] cor(input int k);
    logic [15:0] t [5];
    t = '{{lo, 4'h0} - 16'h1, {lo, 4'h0}, {hi, 4'hf}, {hi, 4'hf} + 16'h1, 16'h8000};
    cor = t[k % 5];
  endfunction : cor
  // one result pair, then enough edges for flags and the alert pin to settle
  task automatic res(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    rv <= 1'b1;
    ra <= a;
    rb <= b;
    ef = ef | {lim(b), 2'b00, lim(a)};
    @(posedge clk);
    rv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : res
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    rv = 1'b0;
    ra = 16'h0;
    rb = 16'h0;
    ef = 6'h0;
    n_mismatch = 0;
    total_checks = 0;
    seed = 21;
    lo = 12'h000;
    hi = 12'hfff;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    hm.rd(4'h4, d, rsp);
    chk("low_reset", 32'h4000, d);
    hm.rd(4'h5, d, rsp);
    chk("high_reset", 32'h5fff, d);
    res(16'h0, 16'hffff);
    hm.rd(4'h3, d, rsp);
    chk("flags_default", {16'h0, 4'h3, 6'h0, ef}, d);
    hm.rd(4'h7, d, rsp);
    chk("unmapped_resp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    hm.wr(4'h7, 12'h000, rsp);
    chk("wr_unmapped", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      lo = 12'($random(seed));
      hi = 12'($random(seed));
      hm.wr(4'h4, lo, rsp);
      hm.wr(4'h5, hi, rsp);
      chk("wr_okay", {30'h0, `RESP_OKAY}, {30'h0, rsp});
      hm.rd(4'h4, d, rsp);
      chk("low_limit", {16'h0, 4'h4, lo}, d);
      hm.rd(4'h5, d, rsp);
      chk("high_limit", {16'h0, 4'h5, hi}, d);
      res(cor(i), cor(i + 2));
      res(16'($random(seed)), 16'($random(seed)));
      chk("alert_pin", {31'h0, |ef}, {31'h0, alert});
      hm.rd(4'h3, d, rsp);
      chk("flags", {16'h0, 4'h3, 6'h0, ef}, d);
      ef = '0;
      hm.rd(4'h3, d, rsp);
      chk("flags_cleared", 32'h3000, d);
    end
    $display("test limits done");
    lo = 12'h800;
    hi = 12'hfff;
    hm.wr(4'h4, lo, rsp);
    hm.wr(4'h5, hi, rsp);
    res(16'h0, 16'h7fff);
    hm.wr(4'h2, 12'h03c, rsp);
    ef = '0;
    hm.rd(4'h3, d, rsp);
    chk("flags_soft", 32'h3000, d);
    hm.rd(4'h4, d, rsp);
    chk("low_kept", 32'h4800, d);
    $display("test soft reset done");
    hm.wr(4'h8, 12'h033, rsp);
    res(16'h0, 16'h8000);
    chk("irq_masked", 32'h0, {31'h0, irq});
    hm.rd(4'h8, d, rsp);
    chk("irq_status", 32'h8001, d);
    hm.wr(4'h9, 12'h033, rsp);
    repeat (2) @(posedge clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    hm.wr(4'h8, 12'h001, rsp);
    repeat (2) @(posedge clk);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("test irq done");
    lo = 12'h800;
    hi = 12'h900;
    hm.wr(4'h4, lo, rsp);
    hm.wr(4'h5, hi, rsp);
    res(16'h0, 16'hffff);
    chk("alert_before_hard", {31'h0, |ef}, {31'h0, alert});
    hm.wr(4'h2, 12'h0ff, rsp);
    ef = '0;
    lo = 12'h000;
    hi = 12'hfff;
    hm.rd(4'h3, d, rsp);
    chk("flags_hard", {16'h0, 4'h3, 6'h0, ef}, d);
    hm.rd(4'h4, d, rsp);
    chk("low_hard", {16'h0, 4'h4, lo}, d);
    hm.rd(4'h5, d, rsp);
    chk("high_hard", {16'h0, 4'h5, hi}, d);
    $display("test hard reset done");
    end_of_test();
  end
endmodule : threshold_alert_monitor_tb
